// *** split_timer_pkg.sv ***
// Constants, register map and carrier types for the split auto-reload timer.
// Assumes an 8-bit special function register port on the system clock.
package split_timer_pkg;

    // Register addresses on the special function register port.
    localparam logic [7:0] ADDR_CLK_CTL = 8'h8e;
    localparam logic [7:0] ADDR_T3_CTL = 8'h91;
    localparam logic [7:0] ADDR_T3_RL_LOW = 8'h92;
    localparam logic [7:0] ADDR_T3_RL_HIGH = 8'h93;
    localparam logic [7:0] ADDR_T3_CNT_LOW = 8'h94;
    localparam logic [7:0] ADDR_T3_CNT_HIGH = 8'h95;
    localparam logic [7:0] ADDR_T2_CTL = 8'hc8;
    localparam logic [7:0] ADDR_T2_RL_LOW = 8'hca;
    localparam logic [7:0] ADDR_T2_RL_HIGH = 8'hcb;
    localparam logic [7:0] ADDR_T2_CNT_LOW = 8'hcc;
    localparam logic [7:0] ADDR_T2_CNT_HIGH = 8'hcd;

    // Control register field positions.
    localparam int CTL_HIGH_FLAG = 7;
    localparam int CTL_LOW_FLAG = 6;
    localparam int CTL_LOW_IRQ_EN = 5;
    localparam int CTL_CAP_EN = 4;
    localparam int CTL_SPLIT = 3;
    localparam int CTL_RUN = 2;
    localparam int CTL_EXT_SEL = 0;

    // Clock control register field positions.
    localparam int CKC_T3_HIGH_SEL = 7;
    localparam int CKC_T3_LOW_SEL = 6;
    localparam int CKC_T2_HIGH_SEL = 5;
    localparam int CKC_T2_LOW_SEL = 4;

    // Reset values and wrap limits.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_CLK_SEL = 4'h0;
    localparam logic [7:0] BYTE_MAX = 8'hff;

    // Timebase divisors.
    localparam int SYS_DIV = 12;
    localparam int EXT_DIV = 8;
    localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
    localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);

    // Software-written settings of one timer.
    typedef struct packed {
        logic low_irq_en;
        logic cap_en;
        logic split;
        logic run;
        logic ext_sel;
    } timer_cfg_type;

    // Write strobes of one timer.
    typedef struct packed {
        logic ctl;
        logic cnt_low;
        logic cnt_high;
        logic rl_low;
        logic rl_high;
    } timer_wr_type;

endpackage : split_timer_pkg

// *** split_timer_core.sv ***
// One timer: count pair, reload pair, overflow flags and interrupt request.
// Assumes timebase ticks and write strobes come from logic on i_mclk.
`timescale 1ns/1ns
module split_timer_core (
    // Clock, reset and enable.
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // Settings and timebase.
    input split_timer_pkg::timer_cfg_type i_cfg,
    input wire logic i_tick_low,
    input wire logic i_tick_high,
    input wire logic i_capture,
    input wire logic i_irq_en,
    // Software writes.
    input split_timer_pkg::timer_wr_type i_wr,
    input wire logic [7:0] i_wdata,
    // State.
    output logic [15:0] o_count,
    output logic [15:0] o_reload,
    output logic o_high_flag,
    output logic o_low_flag,
    output logic o_irq
);
    logic [7:0] cnt_low_q;
    logic [7:0] cnt_high_q;
    logic [7:0] rl_low_q;
    logic [7:0] rl_high_q;
    logic high_flag_q;
    logic low_flag_q;
    logic irq_q;
    logic step16;
    logic step_low;
    logic step_high;
    logic wrap16;
    logic wrap_low;
    logic wrap_high;
    logic cap_fire;

    always_comb begin
        step16 = !i_cfg.split && i_cfg.run && i_tick_low;
        step_low = i_cfg.split && i_tick_low;
        step_high = i_cfg.split && i_cfg.run && i_tick_high;
        wrap_low = (step16 || step_low) &&
            (cnt_low_q == split_timer_pkg::BYTE_MAX);
        wrap16 = step16 && (cnt_low_q == split_timer_pkg::BYTE_MAX) &&
            (cnt_high_q == split_timer_pkg::BYTE_MAX);
        wrap_high = step_high && (cnt_high_q == split_timer_pkg::BYTE_MAX);
        cap_fire = i_capture && i_cfg.cap_en && i_irq_en;
    end

    // Low byte: reload on its own wrap in split mode, on full wrap else.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_low_q <= split_timer_pkg::RST_BYTE;
        end else if (i_ce) begin
            if (i_wr.cnt_low) begin
                cnt_low_q <= i_wdata;
            end else if (wrap16 || (step_low && wrap_low)) begin
                cnt_low_q <= rl_low_q;
            end else if (step16 || step_low) begin
                cnt_low_q <= cnt_low_q + 8'h01;
            end
        end
    end

    // High byte: carry from the low byte, or its own counter in split mode.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_high_q <= split_timer_pkg::RST_BYTE;
        end else if (i_ce) begin
            if (i_wr.cnt_high) begin
                cnt_high_q <= i_wdata;
            end else if (wrap16 || wrap_high) begin
                cnt_high_q <= rl_high_q;
            end else if (step_high || (step16 && wrap_low)) begin
                cnt_high_q <= cnt_high_q + 8'h01;
            end
        end
    end

    // Reload pair: capture of the count wins over a software write.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rl_low_q <= split_timer_pkg::RST_BYTE;
            rl_high_q <= split_timer_pkg::RST_BYTE;
        end else if (i_ce) begin
            if (cap_fire) begin
                rl_low_q <= cnt_low_q;
                rl_high_q <= cnt_high_q;
            end else begin
                if (i_wr.rl_low) begin
                    rl_low_q <= i_wdata;
                end
                if (i_wr.rl_high) begin
                    rl_high_q <= i_wdata;
                end
            end
        end
    end

    // Flags are sticky; hardware setting wins over a software clear.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            high_flag_q <= 1'b0;
            low_flag_q <= 1'b0;
        end else if (i_ce) begin
            high_flag_q <= wrap16 || wrap_high || (i_wr.ctl ?
                i_wdata[split_timer_pkg::CTL_HIGH_FLAG] : high_flag_q);
            low_flag_q <= wrap_low || (i_wr.ctl ?
                i_wdata[split_timer_pkg::CTL_LOW_FLAG] : low_flag_q);
        end
    end

    // Interrupt request gated by the external enable.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_q <= 1'b0;
        end else if (i_ce) begin
            irq_q <= i_irq_en && (high_flag_q || cap_fire ||
                (i_cfg.low_irq_en && low_flag_q));
        end
    end

    assign o_count = {cnt_high_q, cnt_low_q};
    assign o_reload = {rl_high_q, rl_low_q};
    assign o_high_flag = high_flag_q;
    assign o_low_flag = low_flag_q;
    assign o_irq = irq_q;

    chk_flag_sticky: assert property (@(posedge i_mclk)
        disable iff (!i_arst_n)
        high_flag_q && !(i_ce && i_wr.ctl) |=> high_flag_q)
        else $error("High overflow flag cleared without a write.");

endmodule : split_timer_core

// *** split_timer.sv ***
// Two split auto-reload timers behind a special function register port.
// Assumes the core drives the port and interrupt enables on i_mclk;
// the external and low-frequency oscillators arrive unsynchronised.
//
// Summary of operation
// - Split mode runs two independent reloading 8-bit counters.
// - 16-bit wrap loads reload pair, sets high flag.
// - 16-bit mode low-byte wrap may also interrupt.
// - Split bytes reload from their own reload registers.
// - Run bit gates high byte only in split mode.
// - Byte clock: system, divided by 12, external by 8.
// - External divided-by-8 timebase synchronised to system clock.
// - Split mode byte wraps set their own flags.
// - Low flag set on every low-byte wrap.
// - Split mode high wrap interrupts; low when enabled.
// - Flags cleared only by software writes.
// - Second timer interrupt gated by extended enable input.
// - First timer interrupt gated by main enable input.
// - Oscillator rising edge captures count into reload pair while the interrupt enable input is high.
// - Control bits: flags, enables, split, run, clock select.
// - One external select serves both bytes in split.
// - Count registers reset to zero, hold count.
// - High-byte clock select used only in split mode.
// - Low-byte select one means system clock for timer.
`timescale 1ns/1ns
module split_timer (
    // Clock, reset and clock enable.
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // Special function register port.
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    output logic [7:0] o_sfr_rdata,
    // Oscillator inputs from outside the clock domain.
    input wire logic i_ext_clk,
    input wire logic i_lfo_clk,
    // Interrupt enables and requests.
    input wire logic i_t2_irq_en,
    input wire logic i_t3_irq_en,
    output logic o_t2_irq,
    output logic o_t3_irq
);
    logic ext_s1_q;
    logic ext_s2_q;
    logic ext_s3_q;
    logic lfo_s1_q;
    logic lfo_s2_q;
    logic lfo_s3_q;
    logic [2:0] ext_div_q;
    logic [3:0] sys_div_q;
    logic ext_rise;
    logic ext8_tick;
    logic div12_tick;
    logic lfo_rise;
    logic [3:0] clk_sel_q;
    split_timer_pkg::timer_cfg_type t2_cfg_q;
    split_timer_pkg::timer_cfg_type t3_cfg_q;
    split_timer_pkg::timer_wr_type t2_wr;
    split_timer_pkg::timer_wr_type t3_wr;
    logic t2_tick_low;
    logic t2_tick_high;
    logic t3_tick_low;
    logic t3_tick_high;
    logic [15:0] t2_count;
    logic [15:0] t2_reload;
    logic [15:0] t3_count;
    logic [15:0] t3_reload;
    logic t2_high_flag;
    logic t2_low_flag;
    logic t3_high_flag;
    logic t3_low_flag;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic wr_en;

    // Picks the timebase of one byte from its select and the external select.
    function automatic logic byte_tick(input logic sys_sel,
            input logic ext_sel, input logic tick_ext, input logic tick_sys);
        logic tick;
        tick = sys_sel ? 1'b1 : (ext_sel ? tick_ext : tick_sys);
        return tick;
    endfunction : byte_tick

    // Synchronisers for the oscillator pins.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            lfo_s1_q <= 1'b0;
            lfo_s2_q <= 1'b0;
            lfo_s3_q <= 1'b0;
        end else if (i_ce) begin
            ext_s1_q <= i_ext_clk;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            lfo_s1_q <= i_lfo_clk;
            lfo_s2_q <= lfo_s1_q;
            lfo_s3_q <= lfo_s2_q;
        end
    end

    assign ext_rise = i_ce && ext_s2_q && !ext_s3_q;
    assign lfo_rise = i_ce && lfo_s2_q && !lfo_s3_q;
    assign ext8_tick = ext_rise &&
        (ext_div_q == split_timer_pkg::EXT_DIV_LAST);
    assign div12_tick = i_ce &&
        (sys_div_q == split_timer_pkg::SYS_DIV_LAST);

    // External oscillator divided by 8, counted in its synchronised rising edges.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ext_div_q <= 3'h0;
        end else if (ext_rise) begin
            ext_div_q <= ext_div_q + 3'h1;
        end
    end

    // System clock divided by 12.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sys_div_q <= 4'h0;
        end else if (i_ce) begin
            if (div12_tick) begin
                sys_div_q <= 4'h0;
            end else begin
                sys_div_q <= sys_div_q + 4'h1;
            end
        end
    end

    // Byte timebases; the high select is only looked at in split mode.
    always_comb begin
        t2_tick_low = i_ce && byte_tick(
            clk_sel_q[split_timer_pkg::CKC_T2_LOW_SEL - 4],
            t2_cfg_q.ext_sel, ext8_tick, div12_tick);
        t2_tick_high = i_ce && byte_tick(
            clk_sel_q[split_timer_pkg::CKC_T2_HIGH_SEL - 4],
            t2_cfg_q.ext_sel, ext8_tick, div12_tick);
        t3_tick_low = i_ce && byte_tick(
            clk_sel_q[split_timer_pkg::CKC_T3_LOW_SEL - 4],
            t3_cfg_q.ext_sel, ext8_tick, div12_tick);
        t3_tick_high = i_ce && byte_tick(
            clk_sel_q[split_timer_pkg::CKC_T3_HIGH_SEL - 4],
            t3_cfg_q.ext_sel, ext8_tick, div12_tick);
    end

    // Address decode of write strobes.
    assign wr_en = i_ce && i_sfr_wr;
    always_comb begin
        t2_wr.ctl = wr_en && (i_sfr_addr == split_timer_pkg::ADDR_T2_CTL);
        t2_wr.cnt_low = wr_en &&
            (i_sfr_addr == split_timer_pkg::ADDR_T2_CNT_LOW);
        t2_wr.cnt_high = wr_en &&
            (i_sfr_addr == split_timer_pkg::ADDR_T2_CNT_HIGH);
        t2_wr.rl_low = wr_en &&
            (i_sfr_addr == split_timer_pkg::ADDR_T2_RL_LOW);
        t2_wr.rl_high = wr_en &&
            (i_sfr_addr == split_timer_pkg::ADDR_T2_RL_HIGH);
        t3_wr.ctl = wr_en && (i_sfr_addr == split_timer_pkg::ADDR_T3_CTL);
        t3_wr.cnt_low = wr_en &&
            (i_sfr_addr == split_timer_pkg::ADDR_T3_CNT_LOW);
        t3_wr.cnt_high = wr_en &&
            (i_sfr_addr == split_timer_pkg::ADDR_T3_CNT_HIGH);
        t3_wr.rl_low = wr_en &&
            (i_sfr_addr == split_timer_pkg::ADDR_T3_RL_LOW);
        t3_wr.rl_high = wr_en &&
            (i_sfr_addr == split_timer_pkg::ADDR_T3_RL_HIGH);
    end

    // Clock control: only the four timer byte selects live here.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            clk_sel_q <= split_timer_pkg::RST_CLK_SEL;
        end else if (wr_en &&
                (i_sfr_addr == split_timer_pkg::ADDR_CLK_CTL)) begin
            clk_sel_q <= i_sfr_wdata[7:4];
        end
    end

    // Control settings of the first timer.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            t2_cfg_q <= '0;
        end else if (t2_wr.ctl) begin
            t2_cfg_q.low_irq_en <=
                i_sfr_wdata[split_timer_pkg::CTL_LOW_IRQ_EN];
            t2_cfg_q.cap_en <= i_sfr_wdata[split_timer_pkg::CTL_CAP_EN];
            t2_cfg_q.split <= i_sfr_wdata[split_timer_pkg::CTL_SPLIT];
            t2_cfg_q.run <= i_sfr_wdata[split_timer_pkg::CTL_RUN];
            t2_cfg_q.ext_sel <= i_sfr_wdata[split_timer_pkg::CTL_EXT_SEL];
        end
    end

    // Control settings of the second timer.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            t3_cfg_q <= '0;
        end else if (t3_wr.ctl) begin
            t3_cfg_q.low_irq_en <=
                i_sfr_wdata[split_timer_pkg::CTL_LOW_IRQ_EN];
            t3_cfg_q.cap_en <= i_sfr_wdata[split_timer_pkg::CTL_CAP_EN];
            t3_cfg_q.split <= i_sfr_wdata[split_timer_pkg::CTL_SPLIT];
            t3_cfg_q.run <= i_sfr_wdata[split_timer_pkg::CTL_RUN];
            t3_cfg_q.ext_sel <= i_sfr_wdata[split_timer_pkg::CTL_EXT_SEL];
        end
    end

    split_timer_core u_timer2 (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_cfg(t2_cfg_q),
        .i_tick_low(t2_tick_low),
        .i_tick_high(t2_tick_high),
        .i_capture(lfo_rise),
        .i_irq_en(i_t2_irq_en),
        .i_wr(t2_wr),
        .i_wdata(i_sfr_wdata),
        .o_count(t2_count),
        .o_reload(t2_reload),
        .o_high_flag(t2_high_flag),
        .o_low_flag(t2_low_flag),
        .o_irq(o_t2_irq)
    );

    split_timer_core u_timer3 (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_cfg(t3_cfg_q),
        .i_tick_low(t3_tick_low),
        .i_tick_high(t3_tick_high),
        .i_capture(lfo_rise),
        .i_irq_en(i_t3_irq_en),
        .i_wr(t3_wr),
        .i_wdata(i_sfr_wdata),
        .o_count(t3_count),
        .o_reload(t3_reload),
        .o_high_flag(t3_high_flag),
        .o_low_flag(t3_low_flag),
        .o_irq(o_t3_irq)
    );

    // Read multiplexer; unmapped addresses and bit 1 read as zero.
    always_comb begin
        case (i_sfr_addr)
            split_timer_pkg::ADDR_CLK_CTL: rdata_d = {clk_sel_q, 4'h0};
            split_timer_pkg::ADDR_T2_CTL: rdata_d = {t2_high_flag,
                t2_low_flag, t2_cfg_q.low_irq_en, t2_cfg_q.cap_en,
                t2_cfg_q.split, t2_cfg_q.run, 1'b0,
                t2_cfg_q.ext_sel};
            split_timer_pkg::ADDR_T2_RL_LOW: rdata_d = t2_reload[7:0];
            split_timer_pkg::ADDR_T2_RL_HIGH: rdata_d = t2_reload[15:8];
            split_timer_pkg::ADDR_T2_CNT_LOW: rdata_d = t2_count[7:0];
            split_timer_pkg::ADDR_T2_CNT_HIGH: rdata_d = t2_count[15:8];
            split_timer_pkg::ADDR_T3_CTL: rdata_d = {t3_high_flag,
                t3_low_flag, t3_cfg_q.low_irq_en, t3_cfg_q.cap_en,
                t3_cfg_q.split, t3_cfg_q.run, 1'b0,
                t3_cfg_q.ext_sel};
            split_timer_pkg::ADDR_T3_RL_LOW: rdata_d = t3_reload[7:0];
            split_timer_pkg::ADDR_T3_RL_HIGH: rdata_d = t3_reload[15:8];
            split_timer_pkg::ADDR_T3_CNT_LOW: rdata_d = t3_count[7:0];
            split_timer_pkg::ADDR_T3_CNT_HIGH: rdata_d = t3_count[15:8];
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_q <= 8'h00;
        end else if (i_ce && i_sfr_rd) begin
            rdata_q <= rdata_d;
        end
    end

    assign o_sfr_rdata = rdata_q;

    // Named sequences for the checks below.
    sequence s_t2_wrap16;
        i_ce && !t2_cfg_q.split && t2_cfg_q.run && t2_tick_low &&
            (t2_count == 16'hffff) && !t2_wr.cnt_low && !t2_wr.cnt_high;
    endsequence

    sequence s_t3_low_step;
        i_ce && t3_cfg_q.split && t3_tick_low && !t3_wr.cnt_low &&
            (t3_count[7:0] != split_timer_pkg::BYTE_MAX);
    endsequence

    chk_wrap_reload: assert property (@(posedge i_mclk)
        disable iff (!i_arst_n)
        s_t2_wrap16 |=> (t2_count == $past(t2_reload)) && t2_high_flag)
        else $error("16-bit wrap did not reload or set the flag.");

    chk_low_free_run: assert property (@(posedge i_mclk)
        disable iff (!i_arst_n)
        s_t3_low_step |=> t3_count[7:0] == $past(t3_count[7:0]) + 8'h01)
        else $error("Split low byte did not step on its tick.");

    chk_high_run_gate: assert property (@(posedge i_mclk)
        disable iff (!i_arst_n)
        t3_cfg_q.split && !t3_cfg_q.run && !t3_wr.cnt_high
        |=> $stable(t3_count[15:8]))
        else $error("Split high byte moved while stopped.");

    chk_low_flag_set: assert property (@(posedge i_mclk)
        disable iff (!i_arst_n)
        t3_tick_low && (t3_cfg_q.split || t3_cfg_q.run) &&
        (t3_count[7:0] == split_timer_pkg::BYTE_MAX) |=> t3_low_flag)
        else $error("Low byte wrap did not set its flag.");

    chk_irq_gate_t2: assert property (@(posedge i_mclk)
        disable iff (!i_arst_n)
        i_ce && !i_t2_irq_en |=> !o_t2_irq)
        else $error("First timer requested while disabled.");

    chk_irq_gate_t3: assert property (@(posedge i_mclk)
        disable iff (!i_arst_n)
        i_ce && i_t3_irq_en && t3_high_flag |=> o_t3_irq)
        else $error("Second timer did not request on its flag.");

    chk_capture_copy: assert property (@(posedge i_mclk)
        disable iff (!i_arst_n)
        lfo_rise && t3_cfg_q.cap_en && i_t3_irq_en
        |=> (t3_reload == $past(t3_count)) && o_t3_irq)
        else $error("Capture did not copy the count or request.");

    chk_div12_gap: assert property (@(posedge i_mclk)
        disable iff (!i_arst_n || !i_ce)
        div12_tick |=> (!div12_tick) [*8] ##1 (!div12_tick) [*3]
        ##1 div12_tick)
        else $error("Divide by 12 timebase spacing wrong.");

    chk_ext_synced: assert property (@(posedge i_mclk)
        disable iff (!i_arst_n)
        ext8_tick |-> ext_s2_q && !ext_s3_q && $past(ext_s1_q))
        else $error("External tick not from a synchronised edge.");

    chk_unused_bit: assert property (@(posedge i_mclk)
        disable iff (!i_arst_n)
        i_ce && i_sfr_rd && (i_sfr_addr == split_timer_pkg::ADDR_T3_CTL)
        |=> !o_sfr_rdata[1])
        else $error("Unused control bit did not read zero.");

endmodule : split_timer

// *** core_model.sv ***
// Processor core model: register port tasks and the two oscillators.
// Assumes one bench process calls the tasks, timed by i_mclk.
`timescale 1ns/1ns
module core_model (
    // Clock and read data.
    input wire logic i_mclk,
    input wire logic [7:0] i_rdata,
    // Register port.
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    // Oscillators.
    output logic o_ext_clk,
    output logic o_lfo_clk
);
    initial begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_ext_clk = 1'b0;
        o_lfo_clk = 1'b0;
    end
    // Eight system clocks a period, edges clear of the sampling edge.
    always #40 o_ext_clk = ~o_ext_clk;
    // Writes one register; zeros written to flags clear them.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_mclk);
        o_rd <= 1'b0;
        #1 d = i_rdata;
    endtask : rd
    task automatic lfo_rise();
        @(posedge i_mclk);
        o_lfo_clk <= 1'b1;
        repeat (20) @(posedge i_mclk);
        o_lfo_clk <= 1'b0;
    endtask : lfo_rise
endmodule : core_model

// *** split_timer_bench.sv ***
// Self-checking bench for the split auto-reload timer.
// Assumes the core model drives the register port and oscillators.
`timescale 1ns/1ns
module split_timer_bench;
    logic i_mclk, i_arst_n, wr, rd, ext_clk, lfo_clk;
    logic t2_en, t3_en, t2_irq, t3_irq, ce;
    logic [7:0] addr, wdata, rdata, d, r;
    int n_fail, check_count;
    split_timer split_timer_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
        .i_ce(ce), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
        .i_sfr_wr(wr), .i_sfr_rd(rd), .o_sfr_rdata(rdata),
        .i_ext_clk(ext_clk), .i_lfo_clk(lfo_clk), .i_t2_irq_en(t2_en),
        .i_t3_irq_en(t3_en), .o_t2_irq(t2_irq), .o_t3_irq(t3_irq));
    core_model core_model_i (.i_mclk(i_mclk), .i_rdata(rdata),
        .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
        .o_ext_clk(ext_clk), .o_lfo_clk(lfo_clk));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic w(input logic [7:0] a, input logic [7:0] v);
        core_model_i.wr(a, v);
    endtask : w
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        core_model_i.rd(a, d);
        chk(d, exp);
    endtask : rc
    // Control value as read back: the unused bit reads zero.
    function automatic logic [7:0] ctl_val(input logic [7:0] v);
        return {v[7:2], 1'b0, v[0]};
    endfunction : ctl_val
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    initial begin
        #100000;
        n_fail++;
        test_done();
    end
    initial begin
        i_arst_n = 1'b0;
        ce = 1'b1;
        t2_en = 1'b0;
        t3_en = 1'b0;
        n_fail = 0;
        check_count = 0;
        r = 8'($urandom(54653));
        repeat (4) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        rc(split_timer_pkg::ADDR_T2_CNT_LOW, 8'h00);
        rc(split_timer_pkg::ADDR_T2_CNT_HIGH, 8'h00);
        r = 8'($urandom) & 8'h3f;
        w(split_timer_pkg::ADDR_T3_CTL, r);
        rc(split_timer_pkg::ADDR_T3_CTL, ctl_val(r));
        w(split_timer_pkg::ADDR_T3_CTL, 8'h00);
        $display("Test reset and control done");
        // Both low-byte selects on the system clock.
        w(split_timer_pkg::ADDR_CLK_CTL, 8'h50);
        repeat (3) begin
            r = 8'($urandom);
            w(split_timer_pkg::ADDR_T2_RL_LOW, 8'h00);
            w(split_timer_pkg::ADDR_T2_RL_HIGH, r);
            w(split_timer_pkg::ADDR_T2_CNT_LOW, 8'hfe);
            w(split_timer_pkg::ADDR_T2_CNT_HIGH, 8'hff);
            t2_en <= 1'b1;
            w(split_timer_pkg::ADDR_T2_CTL, 8'h04);
            repeat (4) @(posedge i_mclk);
            w(split_timer_pkg::ADDR_T2_CTL, 8'hc0);
            rc(split_timer_pkg::ADDR_T2_CNT_HIGH, r);
            rc(split_timer_pkg::ADDR_T2_CNT_LOW, 8'h04);
            rc(split_timer_pkg::ADDR_T2_CTL, 8'hc0);
            chk({7'h00, t2_irq}, 8'h01);
            t2_en <= 1'b0;
            repeat (2) @(posedge i_mclk);
            chk({7'h00, t2_irq}, 8'h00);
            w(split_timer_pkg::ADDR_T2_CTL, 8'h00);
            rc(split_timer_pkg::ADDR_T2_CTL, 8'h00);
        end
        $display("Test 16-bit wrap done");
        w(split_timer_pkg::ADDR_T3_CNT_HIGH, r);
        w(split_timer_pkg::ADDR_T3_CNT_LOW, 8'hfd);
        w(split_timer_pkg::ADDR_T3_RL_LOW, 8'h80);
        t3_en <= 1'b1;
        w(split_timer_pkg::ADDR_T3_CTL, 8'h08);
        repeat (4) @(posedge i_mclk);
        core_model_i.rd(split_timer_pkg::ADDR_T3_CNT_LOW, d);
        chk(d & 8'hf0, 8'h80);
        rc(split_timer_pkg::ADDR_T3_CNT_HIGH, r);
        rc(split_timer_pkg::ADDR_T3_CTL, 8'h48);
        chk({7'h00, t3_irq}, 8'h00);
        w(split_timer_pkg::ADDR_T3_CTL, 8'he8);
        repeat (2) @(posedge i_mclk);
        chk({7'h00, t3_irq}, 8'h01);
        t3_en <= 1'b0;
        repeat (2) @(posedge i_mclk);
        chk({7'h00, t3_irq}, 8'h00);
        $display("Test split mode done");
        r = 8'($urandom);
        w(split_timer_pkg::ADDR_T3_CTL, 8'h00);
        w(split_timer_pkg::ADDR_T3_CNT_LOW, r);
        w(split_timer_pkg::ADDR_T3_CNT_HIGH, ~r);
        w(split_timer_pkg::ADDR_T3_CTL, 8'h10);
        t3_en <= 1'b1;
        core_model_i.lfo_rise();
        repeat (10) @(posedge i_mclk);
        rc(split_timer_pkg::ADDR_T3_RL_LOW, r);
        rc(split_timer_pkg::ADDR_T3_RL_HIGH, ~r);
        $display("Test capture done");
        // Divided timebases; the enable freeze takes the whole /12 window.
        w(split_timer_pkg::ADDR_CLK_CTL, 8'h00);
        for (int k = 0; k < 2; k++) begin
            r = 8'($urandom);
            w(split_timer_pkg::ADDR_T2_CNT_LOW, r);
            w(split_timer_pkg::ADDR_T2_CTL, {7'h02, k[0]});
            repeat (k ? 62 : 10) @(posedge i_mclk);
            if (k == 0) begin
                ce <= 1'b0;
                repeat (12) @(posedge i_mclk);
                ce <= 1'b1;
            end
            w(split_timer_pkg::ADDR_T2_CTL, 8'h00);
            rc(split_timer_pkg::ADDR_T2_CNT_LOW, r + 8'h01);
        end
        $display("Test timebase done");
        test_done();
    end
endmodule : split_timer_bench
